// [verilog/tbm_pkg.sv]
// Purpose: Shared constants and types for the table block move engine
// Assumes: 32-bit AHB-Lite register window, 16-bit table words
// Notes:   All byte offsets are word aligned
package tbm_pkg;

  localparam int unsigned WORD_W     = 16;
  localparam int unsigned MEM_AW     = 8;
  localparam int unsigned MEM_DEPTH  = 256;
  localparam int unsigned CNT_W      = 12;
  localparam int unsigned DEC_W      = 12;

  // Register byte offsets
  localparam logic [11:0] OFF_CTRL    = 12'h000;
  localparam logic [11:0] OFF_EXEC    = 12'h004;
  localparam logic [11:0] OFF_ACC     = 12'h008;
  localparam logic [11:0] OFF_STACK1  = 12'h00C;
  localparam logic [11:0] OFF_OPERAND = 12'h010;
  localparam logic [11:0] OFF_STATUS  = 12'h014;
  localparam logic [11:0] OFF_SCAN    = 12'h018;
  localparam logic [1:0]  MEM_SEL     = 2'h1;

  // Field positions
  localparam int unsigned CTRL_EN_BIT    = 0;
  localparam int unsigned ST_BUSY_BIT    = 0;
  localparam int unsigned ST_FLAG_BIT    = 1;
  localparam int unsigned ST_RAN_RA_BIT  = 2;
  localparam int unsigned ST_RAN_PB_BIT  = 3;

  localparam logic [CNT_W-1:0]  CNT_ONE  = 12'h001;
  localparam logic [WORD_W-1:0] PTR_ZERO = 16'h0000;
  localparam logic [WORD_W-1:0] PTR_ONE  = 16'h0001;
  localparam logic [31:0]       RD_ZERO  = 32'h0000_0000;

  typedef enum logic [1:0] {
    TBM_OP_NONE    = 2'h0,
    TBM_OP_MOVE    = 2'h1,
    TBM_OP_READ_AD = 2'h2,
    TBM_OP_POP_BOT = 2'h3
  } tbm_op_t;

endpackage : tbm_pkg

// [verilog/tbm_mem_if.sv]
// Purpose: Port bundle between engine and its word store
// Assumes: Combinational read, write on the clock edge
// Notes:   One read and one write address per cycle
`timescale 1ns/100ps
`default_nettype none
interface tbm_mem_if;
  logic [tbm_pkg::MEM_AW-1:0] raddr;
  logic [tbm_pkg::WORD_W-1:0] rdata;
  logic [tbm_pkg::MEM_AW-1:0] waddr;
  logic [tbm_pkg::WORD_W-1:0] wdata;
  logic                       we;
  modport user (output raddr, output waddr, output wdata, output we, input rdata);
  modport store (input raddr, input waddr, input wdata, input we, output rdata);
endinterface : tbm_mem_if
`default_nettype wire

// [verilog/tbm_word_mem.sv]
// Purpose: Flip-flop word store holding the tables
// Assumes: Single clock, asynchronous active-low reset
// Notes:   Read is combinational so a copy takes one cycle per word
`timescale 1ns/100ps
`default_nettype none
module tbm_word_mem (
  // Clock and reset
  input  wire logic  hclk,
  input  wire logic  hresetn,
  // Store port
  tbm_mem_if.store   mp
);

  logic [tbm_pkg::WORD_W-1:0] mem      [tbm_pkg::MEM_DEPTH];
  logic [tbm_pkg::WORD_W-1:0] next_mem [tbm_pkg::MEM_DEPTH];

  assign mp.rdata = mem[mp.raddr];

  always_comb begin
    for (int i = 0; i < tbm_pkg::MEM_DEPTH; i++) begin
      next_mem[i] = mem[i];
    end
    if (mp.we) begin
      next_mem[mp.waddr] = mp.wdata;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < tbm_pkg::MEM_DEPTH; i++) begin
        mem[i] <= tbm_pkg::PTR_ZERO;
      end
    end else begin
      mem <= next_mem;
    end
  end

endmodule : tbm_word_mem
`default_nettype wire

// [verilog/tbm_engine.sv]
// Purpose: Table block move engine with AHB-Lite register window
// Assumes: hclk 100 MHz, one scan ends with each write to the scan register
// Notes:   Bus accesses always take one wait state, more while the engine runs
//
// Chosen here: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
module tbm_engine (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Status
  output logic             table_pointer_flag,
  output logic             busy
);

  typedef enum logic [2:0] {
    TBM_IDLE, TBM_MOVE, TBM_PTR, TBM_XFER, TBM_UPD
  } tbm_state_t;

  function automatic logic [tbm_pkg::MEM_AW-1:0] wrap_addr(
    input logic [tbm_pkg::WORD_W-1:0] base,
    input logic [tbm_pkg::WORD_W-1:0] off
  );
    logic [tbm_pkg::WORD_W-1:0] sum;
    sum = base + off;
    return sum[tbm_pkg::MEM_AW-1:0];
  endfunction : wrap_addr

  tbm_mem_if mp ();

  tbm_word_mem u_mem (
    .hclk    (hclk),
    .hresetn (hresetn),
    .mp      (mp.store)
  );

  // Bus side state
  logic                           dp_pend,      next_dp_pend;
  logic                           dp_write,     next_dp_write;
  logic [tbm_pkg::DEC_W-1:0]      dp_addr,      next_dp_addr;
  logic                           ctrl_en,      next_ctrl_en;
  logic [tbm_pkg::WORD_W-1:0]     acc,          next_acc;
  logic [tbm_pkg::WORD_W-1:0]     stack1,       next_stack1;
  logic [tbm_pkg::WORD_W-1:0]     operand,      next_operand;
  logic [31:0]                    next_hrdata;
  logic                           next_hreadyout;
  logic                           exec_pulse;
  logic                           scan_pulse;
  tbm_pkg::tbm_op_t               exec_op;
  logic                           bus_go;
  logic                           bus_mem;
  logic [tbm_pkg::MEM_AW-1:0]     bus_maddr;
  logic                           bus_mwe;

  // Engine state
  tbm_state_t                     state,        next_state;
  tbm_pkg::tbm_op_t               op,           next_op;
  logic [tbm_pkg::CNT_W-1:0]      idx,          next_idx;
  logic [tbm_pkg::CNT_W-1:0]      cnt,          next_cnt;
  logic [tbm_pkg::WORD_W-1:0]     src,          next_src;
  logic [tbm_pkg::WORD_W-1:0]     dst,          next_dst;
  logic [tbm_pkg::WORD_W-1:0]     len,          next_len;
  logic [tbm_pkg::WORD_W-1:0]     entry,        next_entry;
  logic [tbm_pkg::WORD_W-1:0]     new_ptr,      next_new_ptr;
  logic                           next_flag;
  logic                           ran_ra,       next_ran_ra;
  logic                           ran_pb,       next_ran_pb;
  logic                           next_busy;
  logic [tbm_pkg::WORD_W-1:0]     ptr_val;

  assign bus_go    = dp_pend && (state == TBM_IDLE);
  assign bus_mem   = (dp_addr[tbm_pkg::DEC_W-1:tbm_pkg::DEC_W-2] == tbm_pkg::MEM_SEL);
  assign bus_maddr = dp_addr[tbm_pkg::MEM_AW+1:2];
  assign bus_mwe   = bus_go && bus_mem && dp_write;
  assign exec_op   = tbm_pkg::tbm_op_t'(hwdata[1:0]);
  assign ptr_val   = mp.rdata;

  always_comb begin
    next_dp_pend   = dp_pend;
    next_dp_write  = dp_write;
    next_dp_addr   = dp_addr;
    next_ctrl_en   = ctrl_en;
    next_acc       = acc;
    next_stack1    = stack1;
    next_operand   = operand;
    next_hrdata    = hrdata;
    next_hreadyout = hreadyout;
    exec_pulse     = 1'b0;
    scan_pulse     = 1'b0;
    if (bus_go) begin
      next_dp_pend   = 1'b0;
      next_hreadyout = 1'b1;
      next_hrdata    = tbm_pkg::RD_ZERO;
      if (bus_mem) begin
        next_hrdata[tbm_pkg::WORD_W-1:0] = mp.rdata;
      end else if (dp_write) begin
        unique case (dp_addr)
          tbm_pkg::OFF_CTRL:    next_ctrl_en = hwdata[tbm_pkg::CTRL_EN_BIT];
          tbm_pkg::OFF_EXEC:    exec_pulse   = 1'b1;
          tbm_pkg::OFF_ACC:     next_acc     = hwdata[tbm_pkg::WORD_W-1:0];
          tbm_pkg::OFF_STACK1:  next_stack1  = hwdata[tbm_pkg::WORD_W-1:0];
          tbm_pkg::OFF_OPERAND: next_operand = hwdata[tbm_pkg::WORD_W-1:0];
          tbm_pkg::OFF_SCAN:    scan_pulse   = 1'b1;
          default:              next_ctrl_en = ctrl_en;
        endcase
      end else begin
        unique case (dp_addr)
          tbm_pkg::OFF_CTRL:    next_hrdata[tbm_pkg::CTRL_EN_BIT] = ctrl_en;
          tbm_pkg::OFF_ACC:     next_hrdata[tbm_pkg::WORD_W-1:0]  = acc;
          tbm_pkg::OFF_STACK1:  next_hrdata[tbm_pkg::WORD_W-1:0]  = stack1;
          tbm_pkg::OFF_OPERAND: next_hrdata[tbm_pkg::WORD_W-1:0]  = operand;
          tbm_pkg::OFF_STATUS: begin
            next_hrdata[tbm_pkg::ST_BUSY_BIT]   = busy;
            next_hrdata[tbm_pkg::ST_FLAG_BIT]   = table_pointer_flag;
            next_hrdata[tbm_pkg::ST_RAN_RA_BIT] = ran_ra;
            next_hrdata[tbm_pkg::ST_RAN_PB_BIT] = ran_pb;
          end
          default:              next_hrdata = tbm_pkg::RD_ZERO;
        endcase
      end
    end
    // One wait state per access; stays low while the engine runs
    if (hsel && htrans[1] && hready) begin
      next_dp_pend   = 1'b1;
      next_dp_write  = hwrite;
      next_dp_addr   = haddr[tbm_pkg::DEC_W-1:0];
      next_hreadyout = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_pend   <= 1'b0;
      dp_write  <= 1'b0;
      dp_addr   <= '0;
      ctrl_en   <= 1'b0;
      acc       <= tbm_pkg::PTR_ZERO;
      stack1    <= tbm_pkg::PTR_ZERO;
      operand   <= tbm_pkg::PTR_ZERO;
      hrdata    <= tbm_pkg::RD_ZERO;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      dp_pend   <= next_dp_pend;
      dp_write  <= next_dp_write;
      dp_addr   <= next_dp_addr;
      ctrl_en   <= next_ctrl_en;
      acc       <= next_acc;
      stack1    <= next_stack1;
      operand   <= next_operand;
      hrdata    <= next_hrdata;
      hreadyout <= next_hreadyout;
      hresp     <= 1'b0;
    end
  end

  always_comb begin
    next_state   = state;
    next_op      = op;
    next_idx     = idx;
    next_cnt     = cnt;
    next_src     = src;
    next_dst     = dst;
    next_len     = len;
    next_entry   = entry;
    next_new_ptr = new_ptr;
    next_flag    = table_pointer_flag;
    next_ran_ra  = ran_ra;
    next_ran_pb  = ran_pb;
    mp.raddr     = bus_maddr;
    mp.waddr     = bus_maddr;
    mp.wdata     = hwdata[tbm_pkg::WORD_W-1:0];
    mp.we        = bus_mwe;
    if (scan_pulse) begin
      next_flag   = 1'b0;
      next_ran_ra = 1'b0;
      next_ran_pb = 1'b0;
    end
    unique case (state)
      TBM_IDLE: begin
        if (exec_pulse && ctrl_en) begin
          next_op  = exec_op;
          next_src = acc;
          next_dst = operand;
          next_len = stack1;
          next_idx = '0;
          next_cnt = stack1[tbm_pkg::CNT_W-1:0];
          if (exec_op == tbm_pkg::TBM_OP_MOVE && stack1[tbm_pkg::CNT_W-1:0] != '0) begin
            next_state = TBM_MOVE;
          end
          if (exec_op == tbm_pkg::TBM_OP_READ_AD && !ran_ra) begin
            next_ran_ra = 1'b1;
            next_state  = TBM_PTR;
          end
          if (exec_op == tbm_pkg::TBM_OP_POP_BOT && !ran_pb) begin
            next_ran_pb = 1'b1;
            next_state  = TBM_PTR;
          end
        end
      end
      TBM_MOVE: begin
        mp.raddr = wrap_addr(src, {4'h0, idx});
        mp.waddr = wrap_addr(dst, {4'h0, idx});
        mp.wdata = mp.rdata;
        mp.we    = 1'b1;
        next_idx = idx + tbm_pkg::CNT_ONE;
        if (next_idx == cnt) begin
          next_state = TBM_IDLE;
        end
      end
      TBM_PTR: begin
        mp.raddr   = wrap_addr(src, tbm_pkg::PTR_ZERO);
        mp.we      = 1'b0;
        next_state = TBM_XFER;
        next_flag  = 1'b0;
        if (ptr_val > len) begin
          next_state = TBM_IDLE;
        end else if (op == tbm_pkg::TBM_OP_READ_AD) begin
          next_new_ptr = (ptr_val >= len) ? tbm_pkg::PTR_ONE : ptr_val + tbm_pkg::PTR_ONE;
          // Zero and wrap read entry one
          next_entry   = next_new_ptr;
        end else begin
          next_entry   = ptr_val;
          next_new_ptr = ptr_val - tbm_pkg::PTR_ONE;
          if (ptr_val == tbm_pkg::PTR_ZERO) begin
            next_state = TBM_IDLE;
          end
        end
      end
      TBM_XFER: begin
        mp.raddr   = wrap_addr(src, entry);
        mp.waddr   = wrap_addr(dst, tbm_pkg::PTR_ZERO);
        mp.wdata   = mp.rdata;
        mp.we      = 1'b1;
        next_state = TBM_UPD;
      end
      TBM_UPD: begin
        mp.waddr   = wrap_addr(src, tbm_pkg::PTR_ZERO);
        mp.wdata   = new_ptr;
        mp.we      = 1'b1;
        next_state = TBM_IDLE;
        if (op == tbm_pkg::TBM_OP_READ_AD) begin
          next_flag = (new_ptr == len);
        end else begin
          next_flag = (new_ptr == tbm_pkg::PTR_ZERO);
        end
      end
    endcase
    next_busy = (next_state != TBM_IDLE);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state              <= TBM_IDLE;
      op                 <= tbm_pkg::TBM_OP_NONE;
      idx                <= '0;
      cnt                <= '0;
      src                <= tbm_pkg::PTR_ZERO;
      dst                <= tbm_pkg::PTR_ZERO;
      len                <= tbm_pkg::PTR_ZERO;
      entry              <= tbm_pkg::PTR_ZERO;
      new_ptr            <= tbm_pkg::PTR_ZERO;
      table_pointer_flag <= 1'b0;
      ran_ra             <= 1'b0;
      ran_pb             <= 1'b0;
      busy               <= 1'b0;
    end else begin
      state              <= next_state;
      op                 <= next_op;
      idx                <= next_idx;
      cnt                <= next_cnt;
      src                <= next_src;
      dst                <= next_dst;
      len                <= next_len;
      entry              <= next_entry;
      new_ptr            <= next_new_ptr;
      table_pointer_flag <= next_flag;
      ran_ra             <= next_ran_ra;
      ran_pb             <= next_ran_pb;
      busy               <= next_busy;
    end
  end

endmodule : tbm_engine
`default_nettype wire

// [verification/tbm_checker.sv]
// Purpose: Port-level checks of the table move engine
// Assumes: hready is tied to hreadyout
// Notes:   Bound to the engine at the foot of this file
`timescale 1ns/100ps
`default_nettype none
module tbm_checker (
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // Bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // Status
  input wire logic        table_pointer_flag,
  input wire logic        busy
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic        taken;
  logic        scan_pend;
  logic        next_scan;
  logic [12:0] run_cnt;
  logic [12:0] next_run_cnt;
  assign taken = hsel && htrans[1] && hready;
  // Scan write stays pending until its data phase completes
  always_comb begin
    next_scan = taken ? (hwrite && haddr[11:0] == tbm_pkg::OFF_SCAN) : scan_pend && !hreadyout;
    next_run_cnt = busy ? run_cnt + 13'h0001 : 13'h0000;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scan_pend <= 1'b0;
      run_cnt   <= 13'h0000;
    end else begin
      scan_pend <= next_scan;
      run_cnt   <= next_run_cnt;
    end
  end
  sequence s_one_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  AST_RESP_OKAY: assert property (hresp == 1'b0)
    else $error("error response seen");
  AST_ADDR_WAIT: assert property (taken |=> !hreadyout)
    else $error("no wait state after address phase");
  AST_IDLE_ONE_WAIT: assert property (taken && !busy |=> s_one_wait)
    else $error("idle access not done after one wait");
  AST_STALL_BUSY: assert property (busy && !hreadyout |=> !hreadyout)
    else $error("access finished while engine ran");
  AST_RDATA_STANDS: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
    else $error("read data changed between accesses");
  AST_FLAG_AT_END: assert property ($rose(table_pointer_flag) |-> $fell(busy))
    else $error("flag rose outside pointer update");
  AST_SCAN_CLEAR: assert property (scan_pend && hreadyout |-> !table_pointer_flag)
    else $error("flag survived scan end");
  AST_RUN_BOUND: assert property (run_cnt < 13'h1004)
    else $error("engine run too long");
endmodule : tbm_checker
bind tbm_engine tbm_checker tbm_checker_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .table_pointer_flag(table_pointer_flag), .busy(busy));
`default_nettype wire

// [verification/tbm_ahb_master.sv]
// Purpose: Bus master standing in for the user program
// Assumes: Single word transfers, one slave
// Notes:   A wait over the bound sets hung
`timescale 1ns/100ps
`default_nettype none
module tbm_ahb_master (
  // Clock
  input  wire logic        hclk,
  // Request
  output var  logic        hsel,
  output var  logic [31:0] haddr,
  output var  logic [1:0]  htrans,
  output var  logic        hwrite,
  output var  logic [2:0]  hsize,
  output var  logic [31:0] hwdata,
  // Answer
  input  wire logic        hready,
  input  wire logic [31:0] hrdata
);
  localparam int LIM = 5000;
  logic hung;
  initial begin
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    hung = 1'b0;
  end
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    int n;
    n = 0;
    hsel <= 1'b1;
    haddr <= {20'h0_0000, a};
    htrans <= 2'h2;
    hwrite <= w;
    do begin
      @(posedge hclk);
      n++;
    end while (!hready && n < LIM);
    htrans <= 2'h0;
    // Reads carry a changing pattern so stale data is never trusted
    hwdata <= w ? d : ~hwdata;
    do begin
      @(posedge hclk);
      n++;
    end while (!hready && n < LIM);
    q = hrdata;
    if (n >= LIM) hung = 1'b1;
  endtask : xfer
endmodule : tbm_ahb_master
`default_nettype wire

// [verification/tbm_engine_bench.sv]
// Purpose: Self-checking bench of the table move engine
// Assumes: Model store mirrors every word the bench writes
// Notes:   Store addresses wrap at 256 words
`timescale 1ns/100ps
`default_nettype none
module tbm_engine_bench;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        table_pointer_flag;
  logic        busy;
  int          error_cnt;
  int          num_checks;
  logic [31:0] seed;
  logic [31:0] r;
  logic [15:0] mem [256];

  tbm_engine tbm_engine_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .table_pointer_flag(table_pointer_flag), .busy(busy));
  tbm_ahb_master tbm_ahb_master_i (.hclk(hclk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata));

  always #5 hclk = ~hclk;

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function automatic logic [7:0] ra_next(input logic [7:0] p, input logic [7:0] len);
    return (p >= len) ? 8'h01 : p + 8'h01;
  endfunction : ra_next
  function automatic logic [11:0] wa(input logic [7:0] i);
    return 12'h400 + {2'b00, i, 2'b00};
  endfunction : wa

  task automatic final_report();
    if (tbm_ahb_master_i.hung === 1'b1) error_cnt++;
    if (error_cnt == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    tbm_ahb_master_i.xfer(w, a, d, q);
    if (tbm_ahb_master_i.hung === 1'b1) final_report();
  endtask : bus
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    chk(what, exp, q);
  endtask : rd_chk
  task automatic tw(input logic [7:0] i, input logic [31:0] v);
    mem[i] = v[15:0];
    wr(wa(i), {16'h0000, v[15:0]});
  endtask : tw

  task automatic move_run(input logic [7:0] src, input logic [7:0] dst, input logic [11:0] cnt);
    wr(tbm_pkg::OFF_STACK1, {20'h0_0000, cnt});
    wr(tbm_pkg::OFF_ACC, {24'h00_0000, src});
    wr(tbm_pkg::OFF_OPERAND, {24'h00_0000, dst});
    wr(tbm_pkg::OFF_EXEC, 32'h0000_0001);
    // ascending copy, overlap sees earlier words
    for (int j = 0; j < cnt; j++) mem[dst + j[7:0]] = mem[src + j[7:0]];
    for (int i = 0; i < 256; i++) rd_chk("store word", wa(i[7:0]), {16'h0000, mem[i]});
  endtask : move_run

  task automatic ptr_run(input logic [1:0] op, input logic [7:0] s, input logic [7:0] len,
                         input logic [7:0] dst, input logic [7:0] p0, input logic stop);
    logic [7:0] p;
    logic       f;
    logic       h;
    p = p0;
    h = 1'b0;
    // pointer set in one scan only
    tw(s, {24'h00_0000, p0});
    wr(tbm_pkg::OFF_STACK1, {24'h00_0000, len});
    wr(tbm_pkg::OFF_ACC, {24'h00_0000, s});
    wr(tbm_pkg::OFF_OPERAND, {24'h00_0000, dst});
    for (int k = 0; k < 6; k++) begin
      // second request in one scan is refused
      if (!h) begin
        wr(tbm_pkg::OFF_EXEC, {30'h0000_0000, op});
        wr(tbm_pkg::OFF_EXEC, {30'h0000_0000, op});
      end
      f = 1'b0;
      if (!h && op == tbm_pkg::TBM_OP_READ_AD) begin
        p = ra_next(p, len);
        mem[dst] = mem[s + p];
        f = (p == len);
      end else if (!h && p != 8'h00) begin
        mem[dst] = mem[s + p];
        p = p - 8'h01;
        f = (p == 8'h00);
      end
      mem[s] = {8'h00, p};
      chk("flag pin", {31'h0000_0000, f}, {31'h0000_0000, table_pointer_flag});
      rd_chk("status", tbm_pkg::OFF_STATUS,
             {28'h000_0000, !h && op == 2'h3, !h && op == 2'h2, f, 1'b0});
      rd_chk("dest word", wa(dst), {16'h0000, mem[dst]});
      rd_chk("pointer word", wa(s), {16'h0000, mem[s]});
      wr(tbm_pkg::OFF_SCAN, 32'h0000_0000);
      chk("flag after scan", 32'h0000_0000, {31'h0000_0000, table_pointer_flag});
      // latched wrap flag halts the table
      h = stop && (h || f);
    end
  endtask : ptr_run

  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    error_cnt = 0;
    num_checks = 0;
    seed = 32'h0000_42d9;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd_chk("status", tbm_pkg::OFF_STATUS, 32'h0000_0000);
    rd_chk("unmapped", 12'h01C, 32'h0000_0000);
    rd_chk("store word", wa(8'h05), 32'h0000_0000);
    wr(tbm_pkg::OFF_CTRL, 32'h0000_0001);
    for (int i = 0; i < 256; i++) tw(i[7:0], rnd());
    move_run(8'h10, 8'h40, 12'h001);
    move_run(8'h20, 8'h30, 12'h000);
    move_run(8'h08, 8'h0C, 12'hFFF);
    r = rnd();
    move_run(r[7:0], r[15:8], {4'h0, r[23:16]});
    ptr_run(2'h2, 8'hC8, 8'h03, 8'hD2, 8'h00, 1'b0);
    ptr_run(2'h2, 8'hB0, 8'h02, 8'hB8, 8'h00, 1'b1);
    ptr_run(2'h3, 8'hDC, 8'h05, 8'hE6, 8'h03, 1'b0);
    // Disabled engine must ignore a pointer command
    wr(tbm_pkg::OFF_CTRL, 32'h0000_0000);
    wr(tbm_pkg::OFF_EXEC, 32'h0000_0003);
    rd_chk("ctrl", tbm_pkg::OFF_CTRL, 32'h0000_0000);
    rd_chk("status", tbm_pkg::OFF_STATUS, 32'h0000_0000);
    rd_chk("pointer word", wa(8'hDC), {16'h0000, mem[8'hDC]});
    final_report();
  end
endmodule : tbm_engine_bench
`default_nettype wire
